// File: inc/chan_pkg.sv
// Purpose: shared constants and carriers for the descriptor channel state block
// Assumes: 32-bit register port at the documented offsets, one clock domain
// Notes: offsets are byte addresses within the channel window
package chan_pkg;
    // =====================================================================
    // register map
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATE = 8'h04;
    localparam logic [7:0] OFF_PTR = 8'h0C;
    localparam logic [7:0] OFF_BRSEL = 8'h14;
    // =====================================================================
    // channel state bit positions
    localparam int BIT_GO = 15;
    localparam int BIT_HOLD = 14;
    localparam int BIT_DRAIN = 13;
    localparam int BIT_ROUSE = 12;
    localparam int BIT_FATAL = 11;
    localparam int BIT_EXEC = 10;
    localparam int BIT_RSVD = 9;
    localparam int BIT_BT = 8;
    localparam int MASK_LSB = 16;
    localparam int SEL_MASK_LSB = 16;
    localparam logic [15:0] STATE_RESET = 16'h0000;
    localparam logic [31:0] PTR_RESET = 32'h0000_0000;
    localparam logic [3:0] PTR_ALIGN_ZERO = 4'h0;
    localparam logic [31:0] DESC_BYTES = 32'h0000_0010;
    localparam int FIFO_DEPTH = 16;
    localparam int DATA_W = 32;
    // outcome field bit that marks a partial write-back
    localparam int OUT_DRAIN = 13;
    // =====================================================================
    // command kinds reported by the sequencer
    typedef enum logic [2:0] {
        CMD_NOP = 3'b000,
        CMD_OUT = 3'b001,
        CMD_IN_CONT = 3'b010,
        CMD_IN_FINAL = 3'b011,
        CMD_HALT = 3'b100
    } cmd_kind_t;
    // register access carrier
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } reg_req_t;
    // status write-back carrier
    typedef struct packed {
        logic valid;
        logic [31:0] desc_addr;
        logic [15:0] outcome;
        logic [15:0] residual;
    } wb_t;
endpackage

// File: hw/stream_fifo.sv
// Purpose: buffer between device input data and memory writes
// Assumes: single clock, synchronous valid/ready on both sides
// Notes: flush empties the storage in one cycle
module stream_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_enable,
    input wire logic i_clear,
    // fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready,
    output logic [$clog2(DEPTH):0] o_count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign o_in_ready = (count != DEPTH[AW:0]);
    assign o_out_valid = (count != '0);
    assign o_out_data = mem[rd_ptr];
    assign o_count = count;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_ff @(posedge i_clock) begin
        if (i_enable && push && !i_clear) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (i_enable) begin
            if (i_clear) begin
                wr_ptr <= '0;
                rd_ptr <= '0;
                count <= '0;
            end else begin
                if (push) begin
                    wr_ptr <= wr_ptr + 1'b1;
                end
                if (pop) begin
                    rd_ptr <= rd_ptr + 1'b1;
                end
                count <= count + (AW+1)'(push) - (AW+1)'(pop);
            end
        end
    end
endmodule

// File: hw/chan_state.sv
// Purpose: channel state register, control write port and descriptor pointer
// Assumes: a command sequencer beside this block reports fetches and completions
// Notes: input data is buffered here and drained to memory through o_mem_*
// =========================================================================
// Overview of operation
// - go set starts descriptor execution
// - go cleared aborts, writes status, discards buffer
// - hold suspends transfers, then clears executing
// - drain flushes buffered input, writes status, clears
// - partial write-back marks drain one, final zero
// - rouse on idle channel refetches pointer descriptor
// - halt command idles channel, pointer not advanced
// - rouse cleared after every descriptor fetch
// - fatal error sets fatal, clears executing together
// - fatal cleared only when go cleared
// - executing follows go, hold, halt, fatal
// - branch flag updated on nop, input, output
// - eight condition bits, software and hardware written
// - condition bits evaluated at each command completion except halt
// - go, hold only software; drain, rouse self-clear
// - pointer readable always, written only when stopped
// - control write updates masked low state bits
// - direct writes to state register ignored
// - reserved bits read zero, writes dropped
module chan_state #(
    parameter int DEPTH = chan_pkg::FIFO_DEPTH,
    parameter int WIDTH = chan_pkg::DATA_W
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_enable,
    // register port
    input wire chan_pkg::reg_req_t i_reg,
    output logic [31:0] o_rdata,
    // sequencer events
    input wire logic i_fetch_done,
    input wire logic i_cmd_done,
    input wire chan_pkg::cmd_kind_t i_cmd_kind,
    input wire logic [1:0] i_branch_req,
    input wire logic [31:0] i_branch_addr,
    input wire logic [15:0] i_residual,
    input wire logic i_fatal_err,
    // hardwired condition bit set and clear
    input wire logic [7:0] i_cond_set,
    input wire logic [7:0] i_cond_clr,
    // sequencer controls
    output logic o_run,
    output logic o_fetch_req,
    output logic [31:0] o_fetch_addr,
    output logic o_cond_branch,
    output logic o_abort,
    // status write-back
    output chan_pkg::wb_t o_wb,
    input wire logic i_wb_ack,
    // device input stream
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // memory write stream
    output logic o_mem_valid,
    output logic [WIDTH-1:0] o_mem_data,
    input wire logic i_mem_ready
);
    // =====================================================================
    // state
    logic go;
    logic hold;
    logic drain;
    logic rouse;
    logic fatal;
    logic executing;
    logic branch_taken;
    logic [7:0] cond;
    logic [31:0] ptr;
    logic [15:0] br_mask;
    logic [15:0] br_value;
    logic idle;
    logic wb_pend;
    logic wb_partial;
    logic [15:0] next_state;
    logic [15:0] ctl_mask;
    logic [15:0] ctl_data;
    logic ctl_wr;
    logic go_rise;
    logic go_fall;
    logic input_cmd;
    logic fifo_in_ready;
    logic fifo_clear;
    logic fifo_out_valid;
    logic drain_start;

    function automatic logic cond_match(input logic [7:0] bits, input logic [7:0] mask,
                                        input logic [7:0] value);
        return (bits & mask) == (value & mask);
    endfunction

    function automatic logic [15:0] state_word(input logic [15:0] base);
        logic [15:0] w;
        w = base;
        w[chan_pkg::BIT_RSVD] = 1'b0;
        return w;
    endfunction

    assign ctl_wr = i_reg.wr && (i_reg.addr == chan_pkg::OFF_CTRL);
    assign ctl_mask = i_reg.wdata[chan_pkg::MASK_LSB +: 16];
    assign ctl_data = i_reg.wdata[15:0];
    assign go_rise = ctl_wr && ctl_mask[chan_pkg::BIT_GO] && ctl_data[chan_pkg::BIT_GO] && !go;
    assign go_fall = ctl_wr && ctl_mask[chan_pkg::BIT_GO] && !ctl_data[chan_pkg::BIT_GO] && go;
    assign input_cmd = (i_cmd_kind == chan_pkg::CMD_IN_CONT) ||
                       (i_cmd_kind == chan_pkg::CMD_IN_FINAL);

    always_comb begin
        next_state = state_bits();
        next_state[chan_pkg::BIT_RSVD] = 1'b0;
    end

    function automatic logic [15:0] state_bits();
        logic [15:0] s;
        s = '0;
        s[chan_pkg::BIT_GO] = go;
        s[chan_pkg::BIT_HOLD] = hold;
        s[chan_pkg::BIT_DRAIN] = drain;
        s[chan_pkg::BIT_ROUSE] = rouse;
        s[chan_pkg::BIT_FATAL] = fatal;
        s[chan_pkg::BIT_EXEC] = executing;
        s[chan_pkg::BIT_BT] = branch_taken;
        s[7:0] = cond;
        return s;
    endfunction

    // =====================================================================
    // software control bits go and hold
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            go <= 1'b0;
            hold <= 1'b0;
        end else if (i_enable && ctl_wr) begin
            // only the masked data bits move, never by hardware
            if (ctl_mask[chan_pkg::BIT_GO]) begin
                go <= ctl_data[chan_pkg::BIT_GO];
            end
            if (ctl_mask[chan_pkg::BIT_HOLD]) begin
                hold <= ctl_data[chan_pkg::BIT_HOLD];
            end
        end
    end

    // =====================================================================
    // command bits drain and rouse: software sets, hardware clears
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            drain <= 1'b0;
            rouse <= 1'b0;
        end else if (i_enable) begin
            if (ctl_wr && ctl_mask[chan_pkg::BIT_ROUSE] && ctl_data[chan_pkg::BIT_ROUSE]) begin
                rouse <= 1'b1;
            end else if (i_fetch_done) begin
                rouse <= 1'b0;
            end
            if (ctl_wr && ctl_mask[chan_pkg::BIT_DRAIN] && ctl_data[chan_pkg::BIT_DRAIN]) begin
                drain <= 1'b1;
            end else if (drain && wb_pend && wb_partial && i_wb_ack) begin
                drain <= 1'b0;
            end else if (drain && !input_cmd) begin
                drain <= 1'b0;
            end
        end
    end

    // =====================================================================
    // executing, idle and fatal halt
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            executing <= 1'b0;
            idle <= 1'b0;
            fatal <= 1'b0;
        end else if (i_enable) begin
            if (go_fall) begin
                fatal <= 1'b0;
            end else if (i_fatal_err && go) begin
                fatal <= 1'b1;
            end
            if (go_fall || (i_fatal_err && go)) begin
                executing <= 1'b0;
                idle <= 1'b0;
            end else if (go_rise) begin
                executing <= 1'b1;
                idle <= 1'b0;
            end else if (hold) begin
                executing <= 1'b0;
            end else if (i_cmd_done && i_cmd_kind == chan_pkg::CMD_HALT) begin
                executing <= 1'b0;
                idle <= 1'b1;
            end else if (idle && i_fetch_done && go && !fatal) begin
                // fetch request stands until the refetch is reported
                executing <= 1'b1;
                idle <= 1'b0;
            end else if (go && !fatal && !idle && !executing) begin
                executing <= 1'b1;
            end
        end
    end

    // =====================================================================
    // branch flag and condition bits
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            branch_taken <= 1'b0;
            cond <= 8'h00;
        end else if (i_enable) begin
            if (i_cmd_done && i_cmd_kind != chan_pkg::CMD_HALT) begin
                branch_taken <= o_cond_branch;
            end
            for (int b = 0; b < 8; b++) begin
                if (i_cond_set[b]) begin
                    cond[b] <= 1'b1;
                end else if (i_cond_clr[b]) begin
                    cond[b] <= 1'b0;
                end else if (ctl_wr && ctl_mask[b]) begin
                    cond[b] <= ctl_data[b];
                end
            end
        end
    end

    // branch request: 0 never, 1 if true, 2 if false, 3 always
    always_comb begin
        unique case (i_branch_req)
            2'b00: o_cond_branch = 1'b0;
            2'b01: o_cond_branch = cond_match(cond, br_mask[7:0], br_value[7:0]);
            2'b10: o_cond_branch = !cond_match(cond, br_mask[7:0], br_value[7:0]);
            2'b11: o_cond_branch = 1'b1;
        endcase
    end

    // =====================================================================
    // pointer and branch select
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            ptr <= chan_pkg::PTR_RESET;
            br_mask <= 16'h0000;
            br_value <= 16'h0000;
        end else if (i_enable) begin
            if (i_reg.wr && i_reg.addr == chan_pkg::OFF_PTR && !go && !executing) begin
                ptr <= {i_reg.wdata[31:4], chan_pkg::PTR_ALIGN_ZERO};
            end else if (i_cmd_done && i_cmd_kind != chan_pkg::CMD_HALT) begin
                ptr <= o_cond_branch ? i_branch_addr : ptr + chan_pkg::DESC_BYTES;
            end
            if (i_reg.wr && i_reg.addr == chan_pkg::OFF_BRSEL) begin
                br_mask <= {8'h00, i_reg.wdata[chan_pkg::SEL_MASK_LSB +: 8]};
                br_value <= {8'h00, i_reg.wdata[7:0]};
            end
        end
    end

    // =====================================================================
    // status write-back: partial on drain, final on abort or fatal
    assign drain_start = drain && input_cmd && !wb_pend && !fifo_out_valid;
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            wb_pend <= 1'b0;
            wb_partial <= 1'b0;
            o_wb <= '0;
        end else if (i_enable) begin
            if (wb_pend && i_wb_ack) begin
                wb_pend <= 1'b0;
                o_wb.valid <= 1'b0;
            end else if (!wb_pend && (go_fall || (i_fatal_err && go) || drain_start)) begin
                wb_pend <= 1'b1;
                wb_partial <= drain_start && !go_fall && !i_fatal_err;
                o_wb.valid <= 1'b1;
                o_wb.desc_addr <= ptr;
                o_wb.residual <= i_residual;
                o_wb.outcome <= state_word(state_bits());
                o_wb.outcome[chan_pkg::OUT_DRAIN] <= drain_start && !go_fall &&
                                                     !i_fatal_err;
            end
        end
    end

    // =====================================================================
    // input data buffer, emptied on abort; stalled under hold
    assign fifo_clear = go_fall;
    stream_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_enable(i_enable),
        .i_clear(fifo_clear),
        .i_in_valid(i_in_valid && executing),
        .i_in_data(i_in_data),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(fifo_out_valid),
        .o_out_data(o_mem_data),
        .i_out_ready(i_mem_ready && !hold),
        .o_count()
    );
    // ready while executing with room; a word handed over in the abort cycle or with i_enable low is not stored
    assign o_in_ready = fifo_in_ready && executing;
    assign o_mem_valid = fifo_out_valid && !hold;

    // =====================================================================
    // outputs and read-back; state register ignores writes
    assign o_run = executing && !hold && !fatal;
    assign o_abort = go_fall && i_enable;
    assign o_fetch_req = idle && rouse && go && !fatal;
    assign o_fetch_addr = ptr;

    always_comb begin
        unique case (i_reg.addr)
            chan_pkg::OFF_STATE: o_rdata = {16'h0000, next_state};
            chan_pkg::OFF_PTR: o_rdata = ptr;
            chan_pkg::OFF_BRSEL: o_rdata = {8'h00, br_mask[7:0], 8'h00, br_value[7:0]};
            default: o_rdata = 32'h0000_0000;
        endcase
    end
endmodule

// File: testbench/chan_state_asserts.sv
// Purpose: concurrent checks on the channel state block ports
// Assumes: single clock domain, asynchronous active-low reset
// Notes: attached to every chan_state instance by bind
module chan_state_asserts (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_enable,
    // register port
    input wire chan_pkg::reg_req_t i_reg,
    input wire logic [31:0] o_rdata,
    // sequencer side
    input wire logic i_fetch_done,
    input wire logic i_cmd_done,
    input wire logic i_fatal_err,
    input wire logic o_run,
    input wire logic o_fetch_req,
    input wire logic [31:0] o_fetch_addr,
    input wire logic o_abort,
    input wire chan_pkg::wb_t o_wb,
    input wire logic i_wb_ack
);
    // =====================================================================
    // helpers
    logic ctrl_wr;
    logic ptr_wr;
    assign ctrl_wr = i_enable && i_reg.wr && i_reg.addr == chan_pkg::OFF_CTRL;
    assign ptr_wr = i_enable && i_reg.wr && i_reg.addr == chan_pkg::OFF_PTR;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);
    // =====================================================================
    // checks
    abort_cause_a: assert property (
        o_abort |-> ctrl_wr && i_reg.wdata[31] && !i_reg.wdata[15])
        else $error("abort without a go clear write");
    abort_stop_a: assert property (o_abort |=> !o_run)
        else $error("still running after abort");
    fatal_stop_a: assert property (i_fatal_err && i_enable |=> !o_run && !o_fetch_req)
        else $error("running after fatal error");
    fatal_wb_a: assert property (i_fatal_err && i_enable |=> o_wb.valid)
        else $error("no write-back after fatal error");
    wb_hold_a: assert property (o_wb.valid && !i_wb_ack |=> $stable(o_wb))
        else $error("write-back changed before ack");
    ptr_lock_a: assert property (
        o_run && ptr_wr && !i_cmd_done && !i_fetch_done |=> $stable(o_fetch_addr))
        else $error("pointer written while running");
    fetch_clear_a: assert property (
        i_fetch_done && i_enable && !(ctrl_wr && i_reg.wdata[28]) |=> !o_fetch_req)
        else $error("fetch request after fetch done");
    fetch_idle_a: assert property (o_fetch_req |-> !o_run)
        else $error("fetch request while running");
    rsvd_zero_a: assert property (
        i_reg.addr == chan_pkg::OFF_STATE |-> o_rdata[31:16] == 16'h0000 && !o_rdata[9])
        else $error("reserved state bits read nonzero");
    ptr_align_a: assert property (o_fetch_addr[3:0] == 4'h0)
        else $error("pointer not descriptor aligned");
endmodule

bind chan_state chan_state_asserts u_chk (.i_clock, .i_resetn, .i_enable, .i_reg, .o_rdata,
    .i_fetch_done, .i_cmd_done, .i_fatal_err, .o_run, .o_fetch_req, .o_fetch_addr, .o_abort,
    .o_wb, .i_wb_ack);

// File: testbench/chan_partner.sv
// Purpose: far side model: fetch answers, write-back memory, device input
// Assumes: stall slows every answer; send offers a counting word stream
// Notes: released input data shows the inverse of the word
module chan_partner (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // scenario controls
    input wire logic i_stall,
    input wire logic i_send,
    // channel side
    input wire logic i_fetch_req,
    input wire chan_pkg::wb_t i_wb,
    input wire logic i_in_ready,
    input wire logic i_mem_valid,
    input wire logic [31:0] i_mem_data,
    output logic o_fetch_done,
    output logic o_wb_ack,
    output logic o_in_valid,
    output logic [31:0] o_in_data,
    output logic o_mem_ready,
    output logic [7:0] o_mem_count,
    output logic o_order_bad
);
    logic [31:0] word;
    assign o_in_data = o_in_valid ? word : ~word;
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_fetch_done <= 1'b0;
            o_wb_ack <= 1'b0;
            o_in_valid <= 1'b0;
            o_mem_ready <= 1'b0;
            o_mem_count <= 8'h00;
            o_order_bad <= 1'b0;
            word <= 32'h0000_0000;
        end else begin
            // one pulse per fetch request
            o_fetch_done <= i_fetch_req && !o_fetch_done && !i_stall;
            o_wb_ack <= i_wb.valid && !o_wb_ack && !i_stall;
            o_mem_ready <= !i_stall;
            // an offered word stays until taken
            o_in_valid <= i_send || (o_in_valid && !i_in_ready);
            if (o_in_valid && i_in_ready) begin
                word <= word + 32'h0000_0001;
            end
            if (i_mem_valid && o_mem_ready) begin
                o_mem_count <= o_mem_count + 8'h01;
                o_order_bad <= o_order_bad || i_mem_data !== {24'h0, o_mem_count};
            end
        end
    end
endmodule

// File: testbench/testbench.sv
// Purpose: self-checking bench for the channel state block
// Assumes: partner answers fetches, write-backs and memory writes
// Notes: register rows first, then hand-written cases
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [7:0] raddr;
        logic [31:0] exp;
    } row_t;
    logic i_clock = 1'b0;
    logic i_resetn = 1'b1;
    logic i_enable = 1'b1;
    chan_pkg::reg_req_t i_reg = '0;
    logic i_fetch_done, i_wb_ack, i_in_valid, i_mem_ready;
    logic i_cmd_done = 1'b0;
    logic i_fatal_err = 1'b0;
    chan_pkg::cmd_kind_t i_cmd_kind = chan_pkg::CMD_NOP;
    logic [1:0] i_branch_req = 2'h0;
    logic [31:0] i_branch_addr = 32'h0000_0400;
    logic [15:0] i_residual = 16'h0000;
    logic [7:0] i_cond_set = 8'h00;
    logic [7:0] i_cond_clr = 8'h00;
    logic [31:0] o_rdata, o_fetch_addr, i_in_data, o_mem_data;
    logic o_run, o_fetch_req, o_cond_branch, o_abort, o_in_ready, o_mem_valid;
    chan_pkg::wb_t o_wb;
    logic stall = 1'b0;
    logic send = 1'b0;
    logic [7:0] mem_count;
    logic order_bad;
    int num_errors = 0;
    int n_compared = 0;
    row_t rows [6] = '{'{8'h00, 32'h00FF_00A5, 8'h04, 32'h0000_00A5},
        '{8'h00, 32'h000F_0000, 8'h04, 32'h0000_00A0}, '{8'h00, 32'h0200_FFFF, 8'h04, 32'h0000_00A0},
        '{8'h00, 32'h0000_FFFF, 8'h04, 32'h0000_00A0}, '{8'h04, 32'hFFFF_FFFF, 8'h04, 32'h0000_00A0},
        '{8'h0C, 32'h0000_0100, 8'h0C, 32'h0000_0100}};

    chan_state u_dut (.i_clock, .i_resetn, .i_enable, .i_reg, .o_rdata, .i_fetch_done,
        .i_cmd_done, .i_cmd_kind, .i_branch_req, .i_branch_addr, .i_residual, .i_fatal_err,
        .i_cond_set, .i_cond_clr, .o_run, .o_fetch_req, .o_fetch_addr, .o_cond_branch, .o_abort,
        .o_wb, .i_wb_ack, .i_in_valid, .i_in_data, .o_in_ready, .o_mem_valid, .o_mem_data,
        .i_mem_ready);
    chan_partner u_far (.i_clock, .i_resetn, .i_stall(stall), .i_send(send),
        .i_fetch_req(o_fetch_req), .i_wb(o_wb), .i_in_ready(o_in_ready), .i_mem_valid(o_mem_valid),
        .i_mem_data(o_mem_data), .o_fetch_done(i_fetch_done), .o_wb_ack(i_wb_ack),
        .o_in_valid(i_in_valid), .o_in_data(i_in_data), .o_mem_ready(i_mem_ready),
        .o_mem_count(mem_count), .o_order_bad(order_bad));

    always #12.5 i_clock = ~i_clock;
    // =====================================================================
    // tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_reg <= '{1'b1, 1'b0, a, d};
        @(posedge i_clock);
        i_reg.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string name);
        @(posedge i_clock);
        i_reg.addr <= a;
        @(posedge i_clock);
        #1;
        check(name, o_rdata & m, e);
    endtask
    task automatic cmd(input int k, input logic [1:0] br);
        @(posedge i_clock);
        i_cmd_kind <= chan_pkg::cmd_kind_t'(k);
        i_branch_req <= br;
        i_cmd_done <= 1'b1;
        @(posedge i_clock);
        i_cmd_done <= 1'b0;
    endtask
    task automatic wait_wb;
        for (int n = 0; n < 50; n++) begin
            @(posedge i_clock);
            #1;
            if (o_wb.valid === 1'b1) break;
        end
        check("wb valid", {31'h0, o_wb.valid}, 32'h1);
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // =====================================================================
    // sequence
    initial begin
        i_resetn <= 1'b0;
        repeat (10) @(posedge i_clock);
        i_resetn <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].raddr, 32'hFFFF_FFFF, rows[i].exp, "row");
        end
        wr(8'h00, 32'h8000_8000);
        rd(8'h04, 32'hFFFF_FFFF, 32'h0000_84A0, "go");
        check("run", {31'h0, o_run}, 32'h1);
        wr(8'h0C, 32'h0000_0200);
        rd(8'h0C, 32'hFFFF_FFFF, 32'h0000_0100, "ptr lock");
        wr(8'h00, 32'h4000_4000);
        rd(8'h04, 32'hFFFF_FFFF, 32'h0000_C0A0, "hold");
        wr(8'h00, 32'h4000_0000);
        rd(8'h04, 32'hFFFF_FFFF, 32'h0000_84A0, "unhold");
        // fill the buffer against a stalled memory, then drain it
        @(posedge i_clock);
        i_cmd_kind <= chan_pkg::CMD_IN_CONT;
        stall <= 1'b1;
        send <= 1'b1;
        repeat (24) @(posedge i_clock);
        send <= 1'b0;
        #1;
        check("full", {31'h0, o_in_ready}, 32'h0);
        wr(8'h00, 32'h2000_2000);
        stall <= 1'b0;
        wait_wb();
        check("partial", {31'h0, o_wb.outcome[chan_pkg::OUT_DRAIN]}, 32'h1);
        check("wb addr", o_wb.desc_addr, 32'h0000_0100);
        rd(8'h04, 32'hFFFF_FFFF, 32'h0000_84A0, "drain");
        check("words", {24'h0, mem_count}, 32'h11);
        check("order", {31'h0, order_bad}, 32'h0);
        check("empty", {31'h0, o_mem_valid}, 32'h0);
        cmd(4, 2'h0);
        rd(8'h04, 32'h0000_0400, 32'h0, "halt");
        rd(8'h0C, 32'hFFFF_FFFF, 32'h0000_0100, "halt ptr");
        stall <= 1'b1;
        wr(8'h00, 32'h1000_1000);
        @(posedge i_clock);
        #1;
        check("fetch", {31'h0, o_fetch_req}, 32'h1);
        check("fetch addr", o_fetch_addr, 32'h0000_0100);
        @(posedge i_clock);
        stall <= 1'b0;
        repeat (3) @(posedge i_clock);
        rd(8'h04, 32'h0000_1000, 32'h0, "rouse");
        wr(8'h14, 32'h000F_0000);
        for (int k = 0; k < 4; k++) begin
            cmd(k, k[1:0]);
            rd(8'h04, 32'h0000_01FF, {23'h0, k[0], 8'hA0}, "branch");
        end
        @(posedge i_clock);
        i_cond_set <= 8'h01;
        i_cond_clr <= 8'h80;
        @(posedge i_clock);
        i_cond_set <= 8'h00;
        i_cond_clr <= 8'h00;
        rd(8'h04, 32'h0000_00FF, 32'h0000_0021, "cond");
        cmd(0, 2'h2);
        rd(8'h04, 32'h0000_0100, 32'h0000_0100, "branch false");
        check("cond branch", {31'h0, o_cond_branch}, 32'h1);
        @(posedge i_clock);
        i_fatal_err <= 1'b1;
        @(posedge i_clock);
        i_fatal_err <= 1'b0;
        wr(8'h00, 32'h0800_0000);
        rd(8'h04, 32'hFFFF_FFFF, 32'h0000_8921, "fatal");
        wr(8'h00, 32'h8000_0000);
        wait_wb();
        check("final", {31'h0, o_wb.outcome[chan_pkg::OUT_DRAIN]}, 32'h0);
        rd(8'h04, 32'hFFFF_FFFF, 32'h0000_0121, "abort");
        wr(8'h0C, 32'h0000_0300);
        rd(8'h0C, 32'hFFFF_FFFF, 32'h0000_0300, "ptr idle");
        wr(8'h00, 32'h8000_8000);
        @(posedge i_clock);
        i_resetn <= 1'b0;
        repeat (3) @(posedge i_clock);
        i_resetn <= 1'b1;
        rd(8'h04, 32'hFFFF_FFFF, 32'h0, "reset state");
        rd(8'h0C, 32'hFFFF_FFFF, 32'h0, "reset ptr");
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge i_clock);
        num_errors++;
        give_verdict();
    end
endmodule
